//--- t16w_waveform_ctrl.sv
// 16-bit timer with waveform generation mode decode and two compare outputs
// Function
// - Active output mode overrides pin port function
// - Waveform drives pin only when direction output
// - Non-PWM: off, toggle, clear, set on match
// - Fast PWM: clear/set on match, opposite at bottom
// - Fast PWM toggle only channel A, mode 15
// - Fast PWM: compare equal top ignored, bottom acts
// - Dual-slope: clear up-match, set down-match, or reverse
// - Dual-slope toggle channel A only, mode 9
// - Force bits act only in non-PWM modes
// - Force bit applies immediate match to output
// - Force bits are strobes using current mode
// - Forced match sets no flag, no clear
// - Force bit positions always read zero
// - Mode is low bits plus two high bits
// - Modes 0, 4, 12: normal/clear-on-match, immediate
// - Modes 5-7, 14, 15 fast PWM, bottom update
// - Modes 1-3, 10, 11 phase correct, top update
// - Modes 8, 9 phase-frequency correct, bottom update
// - High mode bits sit at control B 4:3
// - Dual-slope compare at top/bottom holds level
`timescale 1ns/100ps
`default_nettype none
module t16w_waveform_ctrl
    import t16w_pkg::*;
#(
    parameter int PRESCALE = 1
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [3:0]  regAddr,
    input  wire logic [15:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output var  logic [15:0] regRdData,
    // Port direction and normal port data
    input  wire logic        dirA,
    input  wire logic        dirB,
    input  wire logic        portOutA,
    input  wire logic        portOutB,
    // Pin drivers
    output var  logic        pinOutA,
    output var  logic        pinOeA,
    output var  logic        pinOutB,
    output var  logic        pinOeB,
    // Live overflow flag
    output var  logic        overflowFlag
);

    // Mode family decode
    function automatic t16w_kind_t mode_kind(input logic [3:0] m);
        case (m)
            4'd0:                      mode_kind = KIND_NORMAL;
            4'd4, 4'd12:               mode_kind = KIND_CTC;
            4'd5, 4'd6, 4'd7,
            4'd14, 4'd15:              mode_kind = KIND_FAST;
            4'd1, 4'd2, 4'd3,
            4'd10, 4'd11:              mode_kind = KIND_PHASE;
            4'd8, 4'd9:                mode_kind = KIND_PFC;
            default:                   mode_kind = KIND_RSVD;
        endcase
    endfunction

    // Top value per mode
    function automatic logic [15:0] top_value(input logic [3:0] m,
                                              input logic [15:0] cmpA,
                                              input logic [15:0] cap);
        case (m)
            4'd1, 4'd5:                top_value = TOP_8BIT;
            4'd2, 4'd6:                top_value = TOP_9BIT;
            4'd3, 4'd7:                top_value = TOP_10BIT;
            4'd4, 4'd9, 4'd11, 4'd15:  top_value = cmpA;
            4'd8, 4'd10, 4'd12, 4'd14: top_value = cap;
            default:                   top_value = COUNT_MAX;
        endcase
    endfunction

    // Is the output mode field connected to the pin
    function automatic logic chan_connected(input logic [1:0] om,
                                            input t16w_kind_t k,
                                            input logic toggleOk);
        if (om == OUT_OFF) begin
            chan_connected = 1'b0;
        end else if (om == OUT_TOGGLE && (k == KIND_FAST || k == KIND_PHASE
                                          || k == KIND_PFC)) begin
            chan_connected = toggleOk;
        end else begin
            chan_connected = 1'b1;
        end
    endfunction

    // Next waveform level for one channel
    function automatic logic wave_next(input logic cur,
                                       input logic [1:0] om,
                                       input t16w_kind_t k,
                                       input logic hit,
                                       input logic bottom,
                                       input logic atTopCmp,
                                       input logic atBotCmp,
                                       input logic up,
                                       input logic forced);
        logic v;
        v = cur;
        case (k)
            KIND_NORMAL, KIND_CTC: begin
                if (hit || forced) begin
                    case (om)
                        OUT_TOGGLE: v = ~cur;
                        OUT_CLEAR:  v = 1'b0;
                        OUT_SET:    v = 1'b1;
                        default:    v = cur;
                    endcase
                end
            end
            KIND_FAST: begin
                if (om == OUT_TOGGLE) begin
                    if (hit) begin
                        v = ~cur;
                    end
                end else if (om[1]) begin
                    if (bottom) begin
                        v = (om == OUT_CLEAR);
                    end else if (hit && !atTopCmp) begin
                        v = (om == OUT_SET);
                    end
                end
            end
            KIND_PHASE, KIND_PFC: begin
                if (om == OUT_TOGGLE) begin
                    if (hit) begin
                        v = ~cur;
                    end
                end else if (om[1] && hit) begin
                    if (atTopCmp) begin
                        v = (om == OUT_CLEAR);
                    end else if (atBotCmp) begin
                        v = (om == OUT_SET);
                    end else begin
                        v = up ? (om == OUT_SET) : (om == OUT_CLEAR);
                    end
                end
            end
            default: v = cur;
        endcase
        return v;
    endfunction

    // Software visible registers and internal timer state
    t16w_ctrl_a_t ctrlA;
    logic [1:0]   waveHigh;
    logic         runEnable;
    logic [15:0]  cmpBufA;
    logic [15:0]  cmpBufB;
    logic [15:0]  cmpA;
    logic [15:0]  cmpB;
    logic [15:0]  capture;
    logic [15:0]  count;
    logic         countUp;
    logic         blockMatch;
    logic [15:0]  prescaleCnt;
    logic         waveA;
    logic         waveB;

    // Decoded access strobes
    wire logic wrCtrlA  = regWr && (regAddr == ADDR_CTRL_A);
    wire logic wrCtrlB  = regWr && (regAddr == ADDR_CTRL_B);
    wire logic wrCmpA   = regWr && (regAddr == ADDR_CMP_A);
    wire logic wrCmpB   = regWr && (regAddr == ADDR_CMP_B);
    wire logic wrCap    = regWr && (regAddr == ADDR_CAPTURE);
    wire logic wrCount  = regWr && (regAddr == ADDR_COUNT);
    wire logic wrStatus = regWr && (regAddr == ADDR_STATUS);
    wire t16w_ctrl_a_t wrFields = t16w_ctrl_a_t'(regWrData[7:0]);

    // Combined mode and family
    wire logic [3:0] waveMode = {waveHigh, ctrlA.waveLow};
    wire t16w_kind_t kind     = mode_kind(waveMode);
    wire logic nonPwm   = (kind == KIND_NORMAL) || (kind == KIND_CTC);
    wire logic dualSlope = (kind == KIND_PHASE) || (kind == KIND_PFC);
    wire logic [15:0] topVal = top_value(waveMode, cmpA, capture);

    // Timer clock enable from the divider
    wire logic prescaleEnd = (prescaleCnt == 16'(PRESCALE - 1));
    wire logic tick        = runEnable && prescaleEnd;

    // Count position events
    wire logic atTop    = (count == topVal);
    wire logic atBottom = (count == COUNT_BOTTOM);
    wire logic atMax    = (count == COUNT_MAX);
    wire logic hitA = tick && !blockMatch && (count == cmpA);
    wire logic hitB = tick && !blockMatch && (count == cmpB);
    // Fast PWM bottom is the wrap from top
    wire logic fastBottom = tick && (kind == KIND_FAST) && atTop;

    // Next count and direction
    wire logic next_countUp = atBottom ? 1'b1 : (atTop ? 1'b0 : countUp);
    wire logic [15:0] next_count =
        dualSlope ? (next_countUp ? count + 16'h0001 : count - 16'h0001)
                  : (atTop ? COUNT_BOTTOM : count + 16'h0001);

    // Compare buffer update instants
    wire logic updImmediate = nonPwm;
    wire logic updAtTop     = tick && (kind == KIND_PHASE) && atTop;
    wire logic updAtBottom  = fastBottom
                            || (tick && (kind == KIND_PFC) && atBottom);
    wire logic cmpUpdate    = updImmediate || updAtTop || updAtBottom;

    // Overflow instants per family
    wire logic ovfEvent =
        tick && ((nonPwm && atMax)
                 || ((kind == KIND_FAST) && atTop)
                 || (dualSlope && atBottom));

    // Force strobes only in non-PWM modes, never stored
    wire logic forceA = wrCtrlA && wrFields.forceA && nonPwm;
    wire logic forceB = wrCtrlA && wrFields.forceB && nonPwm;

    // Toggle permission per channel in PWM families
    wire logic toggleOkA = ((kind == KIND_FAST) && (waveMode == MODE_FAST_CMPA))
                         || (dualSlope && ((waveMode == MODE_PFC_CMPA)
                                           || (waveMode == MODE_FAST_CAP)));
    wire logic connA = chan_connected(ctrlA.outModeA, kind, toggleOkA);
    wire logic connB = chan_connected(ctrlA.outModeB, kind, 1'b0);

    // Waveform next levels
    wire logic next_waveA = wave_next(waveA, ctrlA.outModeA, kind, hitA, fastBottom,
                                      cmpA == topVal, cmpA == COUNT_BOTTOM,
                                      countUp, forceA);
    wire logic next_waveB = wave_next(waveB, ctrlA.outModeB, kind, hitB, fastBottom,
                                      cmpB == topVal, cmpB == COUNT_BOTTOM,
                                      countUp, forceB);

    // Pin selection: waveform or normal port data, gated by direction
    wire t16w_pin_t next_pinA = '{level: connA ? waveA : portOutA, enable: dirA};
    wire t16w_pin_t next_pinB = '{level: connB ? waveB : portOutB, enable: dirB};

    // Read data selection
    // Write-only force positions are never stored, so they read zero
    logic [15:0] readMux;
    always_comb begin
        case (regAddr)
            ADDR_CTRL_A:  readMux = {8'h00, ctrlA.outModeA, ctrlA.outModeB,
                                     2'b00, ctrlA.waveLow};
            ADDR_CTRL_B:  readMux = (16'(waveHigh) << CTRL_B_WAVE_HI)
                                    | (16'(runEnable) << CTRL_B_RUN);
            ADDR_CMP_A:   readMux = cmpBufA;
            ADDR_CMP_B:   readMux = cmpBufB;
            ADDR_CAPTURE: readMux = capture;
            ADDR_COUNT:   readMux = count;
            ADDR_STATUS:  readMux = 16'(overflowFlag) << STATUS_OVF;
            default:      readMux = WORD_RESET;
        endcase
    end

    // Control registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrlA     <= t16w_ctrl_a_t'(CTRL_A_RESET);
            waveHigh  <= WAVE_HI_RESET;
            runEnable <= 1'b0;
        end else begin
            if (wrCtrlA) begin
                ctrlA <= '{outModeA: wrFields.outModeA, outModeB: wrFields.outModeB,
                           forceA: 1'b0, forceB: 1'b0,
                           waveLow: wrFields.waveLow};
            end
            if (wrCtrlB) begin
                waveHigh  <= regWrData[CTRL_B_WAVE_HI +: 2];
                runEnable <= regWrData[CTRL_B_RUN];
            end
        end
    end

    // Compare buffers, active compares and capture
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cmpBufA <= WORD_RESET;
            cmpBufB <= WORD_RESET;
            cmpA    <= WORD_RESET;
            cmpB    <= WORD_RESET;
            capture <= WORD_RESET;
        end else begin
            if (wrCmpA) begin
                cmpBufA <= regWrData;
            end
            if (wrCmpB) begin
                cmpBufB <= regWrData;
            end
            if (wrCap) begin
                capture <= regWrData;
            end
            if (cmpUpdate) begin
                cmpA <= cmpBufA;
                cmpB <= cmpBufB;
            end
        end
    end

    // Prescaler divider
    // Held at zero while stopped, so a restart gives a whole period
    always_ff @(posedge ref_clk) begin
        if (rst || !runEnable || prescaleEnd) begin
            prescaleCnt <= WORD_RESET;
        end else begin
            prescaleCnt <= prescaleCnt + 16'h0001;
        end
    end

    // Counter; a forced match never reloads it
    // A count write hides the match on the next tick, so reloading
    // onto a compare value does not disturb the outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count      <= WORD_RESET;
            countUp    <= 1'b1;
            blockMatch <= 1'b0;
        end else if (wrCount) begin
            count      <= regWrData;
            blockMatch <= 1'b1;
        end else if (tick) begin
            count      <= next_count;
            countUp    <= next_countUp;
            blockMatch <= 1'b0;
        end
    end

    // Overflow flag, set wins over write-one clear
    // An event in the clearing cycle survives, so none is lost
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            overflowFlag <= 1'b0;
        end else if (ovfEvent) begin
            overflowFlag <= 1'b1;
        end else if (wrStatus && regWrData[STATUS_OVF]) begin
            overflowFlag <= 1'b0;
        end
    end

    // Waveform levels; forced match raises no flag
    // Levels are kept while an output mode field is off, so reconnecting
    // shows the last level rather than a reset value
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            waveA <= 1'b0;
            waveB <= 1'b0;
        end else begin
            waveA <= next_waveA;
            waveB <= next_waveB;
        end
    end

    // Registered pins and read data
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pinOutA   <= 1'b0;
            pinOeA    <= 1'b0;
            pinOutB   <= 1'b0;
            pinOeB    <= 1'b0;
            regRdData <= WORD_RESET;
        end else begin
            pinOutA   <= next_pinA.level;
            pinOeA    <= next_pinA.enable;
            pinOutB   <= next_pinB.level;
            pinOeB    <= next_pinB.enable;
            regRdData <= regRd ? readMux : WORD_RESET;
        end
    end

endmodule
`default_nettype wire

//--- t16w_pkg.sv
// Constants and types for the 16-bit timer waveform control block
package t16w_pkg;
    // Register indexes on the plain register port
    localparam logic [3:0] ADDR_CTRL_A   = 4'h0;
    localparam logic [3:0] ADDR_CTRL_B   = 4'h1;
    localparam logic [3:0] ADDR_CMP_A    = 4'h2;
    localparam logic [3:0] ADDR_CMP_B    = 4'h3;
    localparam logic [3:0] ADDR_CAPTURE  = 4'h4;
    localparam logic [3:0] ADDR_COUNT    = 4'h5;
    localparam logic [3:0] ADDR_STATUS   = 4'h6;
    // Control B and status field positions
    localparam int         CTRL_B_WAVE_HI = 3;
    localparam int         CTRL_B_RUN     = 0;
    localparam int         STATUS_OVF     = 0;
    // Reset values
    localparam logic [7:0]  CTRL_A_RESET = 8'h00;
    localparam logic [1:0]  WAVE_HI_RESET = 2'h0;
    localparam logic [15:0] WORD_RESET   = 16'h0000;
    // Fixed count limits
    localparam logic [15:0] COUNT_MAX  = 16'hffff;
    localparam logic [15:0] TOP_8BIT   = 16'h00ff;
    localparam logic [15:0] TOP_9BIT   = 16'h01ff;
    localparam logic [15:0] TOP_10BIT  = 16'h03ff;
    localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
    // Output mode field codes
    localparam logic [1:0] OUT_OFF    = 2'h0;
    localparam logic [1:0] OUT_TOGGLE = 2'h1;
    localparam logic [1:0] OUT_CLEAR  = 2'h2;
    localparam logic [1:0] OUT_SET    = 2'h3;
    // Mode numbers with special output behaviour
    localparam logic [3:0] MODE_PFC_CMPA  = 4'd9;
    localparam logic [3:0] MODE_FAST_CAP  = 4'd14;
    localparam logic [3:0] MODE_FAST_CMPA = 4'd15;

    // Control register A layout
    typedef struct packed {
        logic [1:0] outModeA;
        logic [1:0] outModeB;
        logic       forceA;
        logic       forceB;
        logic [1:0] waveLow;
    } t16w_ctrl_a_t;

    // Pin drive bundle
    typedef struct packed {
        logic level;
        logic enable;
    } t16w_pin_t;

    // Waveform families
    typedef enum logic [2:0] {
        KIND_NORMAL,
        KIND_CTC,
        KIND_FAST,
        KIND_PHASE,
        KIND_PFC,
        KIND_RSVD
    } t16w_kind_t;
endpackage

//--- t16w_waveform_ctrl_asserts.sv
// Assertion checker for the 16-bit timer waveform control block
`timescale 1ns/100ps
`default_nettype none
module t16w_waveform_ctrl_asserts
    import t16w_pkg::*;
(
    // Clock, reset and register port
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic [3:0]  regAddr,
    input wire logic [15:0] regWrData,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [15:0] regRdData,
    // Port side
    input wire logic        dirA,
    input wire logic        dirB,
    input wire logic        portOutA,
    input wire logic        portOutB,
    input wire logic        pinOutA,
    input wire logic        pinOeA,
    input wire logic        pinOutB,
    input wire logic        pinOeB,
    input wire logic        overflowFlag
);
    logic [7:0] shA;
    logic [4:0] shB;
    logic [3:0] nMode;
    logic       nPwm;
    logic       frcA;
    // Shadow copies of both control registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            shA <= 8'h00;
            shB <= 5'h00;
        end else if (regWr && regAddr == ADDR_CTRL_A) begin
            shA <= regWrData[7:0];
        end else if (regWr && regAddr == ADDR_CTRL_B) begin
            shB <= regWrData[4:0];
        end
    end
    // Forced match on channel A with an unchanged driving field, timer stopped
    assign nMode = {shB[4:3], regWrData[1:0]};
    assign nPwm  = !(nMode inside {4'd0, 4'd4, 4'd12});
    assign frcA  = regWr && regAddr == ADDR_CTRL_A && regWrData[3] && !shB[0]
                   && regWrData[7] && regWrData[7:6] == shA[7:6];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    dir_oe_a: assert property (!$past(rst) |-> pinOeA == $past(dirA))
        else $error("pin A enable does not follow direction");
    dir_oe_b_a: assert property (!$past(rst) |-> pinOeB == $past(dirB))
        else $error("pin B enable does not follow direction");
    rd_idle_a: assert property (!$past(regRd) |-> regRdData == 16'h0000)
        else $error("read data not zero outside read answer");
    ctrl_rd_a: assert property ($past(regRd) && $past(regAddr) == ADDR_CTRL_A
        |-> regRdData == {8'h00, $past(shA) & 8'hf3})
        else $error("control A read back wrong");
    mode_hi_a: assert property ($past(regRd) && $past(regAddr) == ADDR_CTRL_B
        |-> regRdData[4:3] == $past(shB[4:3]))
        else $error("high mode bits read back wrong");
    port_pass_a: assert property (!$past(rst) && $past(shA[7:6]) == OUT_OFF
        |-> pinOutA == $past(portOutA))
        else $error("pin A not on port data");
    port_pass_b_a: assert property (!$past(rst) && $past(shA[5:4]) == OUT_OFF
        |-> pinOutB == $past(portOutB))
        else $error("pin B not on port data");
    force_lvl_a: assert property (frcA && !nPwm
        |-> ##2 pinOutA == $past(regWrData[6], 2))
        else $error("forced match gave wrong level");
    pwm_force_a: assert property (frcA && nPwm && regWrData[1:0] == shA[1:0]
        |-> ##2 $stable(pinOutA))
        else $error("force acted in a pwm mode");
    // Main scenarios
    force_np_c: cover property (frcA && !nPwm);
    force_pwm_c: cover property (frcA && nPwm);
    ovf_c: cover property (overflowFlag);
endmodule
bind t16w_waveform_ctrl t16w_waveform_ctrl_asserts i_chk (
    .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .dirA(dirA), .dirB(dirB),
    .portOutA(portOutA), .portOutB(portOutB), .pinOutA(pinOutA), .pinOeA(pinOeA),
    .pinOutB(pinOutB), .pinOeB(pinOeB), .overflowFlag(overflowFlag)
);
`default_nettype wire

//--- test_t16w_waveform_ctrl.sv
// Self-checking testbench for the 16-bit timer waveform control block
`timescale 1ns/100ps
`default_nettype none
module test_t16w_waveform_ctrl
    import t16w_pkg::*;
;
    `define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
        $display("unexpected %s expected %h seen %h", nm, e, g); end end
    localparam logic [1:0] FOM [4] = '{OUT_SET, OUT_CLEAR, OUT_TOGGLE, OUT_TOGGLE};
    localparam logic       FLV [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    localparam logic [3:0] RADR [5] = '{ADDR_CTRL_A, ADDR_CTRL_B, ADDR_CMP_A, ADDR_STATUS, 4'hf};
    logic        ref_clk   = 1'b0;
    logic        rst       = 1'b1;
    logic [3:0]  regAddr   = 4'h0;
    logic [15:0] regWrData = 16'h0000;
    logic        regWr     = 1'b0;
    logic        regRd     = 1'b0;
    logic        dirA      = 1'b0;
    logic        dirB      = 1'b0;
    logic        portOutA  = 1'b0;
    logic        portOutB  = 1'b0;
    logic [15:0] regRdData;
    logic        pinOutA;
    logic        pinOeA;
    logic        pinOutB;
    logic        pinOeB;
    logic        overflowFlag;
    int          n_fail    = 0;
    int          cmp_count = 0;
    // 125 MHz clock
    always #4 ref_clk = ~ref_clk;
    t16w_waveform_ctrl #(.PRESCALE(1)) i_dut (
        .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .dirA(dirA), .dirB(dirB),
        .portOutA(portOutA), .portOutB(portOutB), .pinOutA(pinOutA), .pinOeA(pinOeA),
        .pinOutB(pinOutB), .pinOeB(pinOeB), .overflowFlag(overflowFlag)
    );
    // Register port bus cycles
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge ref_clk);
        regWr     <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge ref_clk);
        regRd   <= 1'b0;
        #1;
        `CHK("regRdData", e, regRdData)
    endtask
    // Let the wave stage and the pin stage land
    task automatic settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    task automatic ports(input logic v);
        @(posedge ref_clk);
        portOutA <= v;
        portOutB <= v;
        dirA     <= v;
        dirB     <= v;
        settle();
    endtask
    // Restart the counter and count high cycles of pin A over n cycles after a 2n cycle lead-in
    task automatic pwm(input logic [15:0] cb, ca, cmp, input int n, e);
        int c;
        c = 0;
        wr(ADDR_CTRL_B, 16'h0000);
        wr(ADDR_COUNT, 16'h0000);
        wr(ADDR_CMP_A, cmp);
        wr(ADDR_CTRL_A, ca);
        wr(ADDR_CTRL_B, cb);
        repeat (2 * n) @(posedge ref_clk);
        repeat (n) begin
            @(posedge ref_clk);
            #1;
            c += pinOutA;
        end
        `CHK("high cycles", e, c)
    endtask
    task automatic finish_test();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #200000;
        n_fail++;
        finish_test();
    end
    // Main sequence
    initial begin
        int k;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++) rd_chk(RADR[i], 16'h0000);
        for (int v = 1; v >= 0; v--) begin
            ports(v[0]);
            `CHK("pinOutA", v[0], pinOutA)
            `CHK("pinOeA", v[0], pinOeA)
            `CHK("pinOutB", v[0], pinOutB)
            `CHK("pinOeB", v[0], pinOeB)
        end
        // Forced matches in clear-on-match mode, timer stopped
        wr(ADDR_CTRL_B, 16'h0008);
        wr(ADDR_COUNT, 16'h0012);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CTRL_A, {8'h00, FOM[i], 6'h00});
            wr(ADDR_CTRL_A, {8'h00, FOM[i], 6'h08});
            settle();
            `CHK("pinOutA", FLV[i], pinOutA)
        end
        wr(ADDR_CTRL_A, 16'h0030);
        wr(ADDR_CTRL_A, 16'h0034);
        settle();
        `CHK("pinOutB", 1'b1, pinOutB)
        rd_chk(ADDR_COUNT, 16'h0012);
        `CHK("overflowFlag", 1'b0, overflowFlag)
        // Force ignored in fast pwm, force bits read zero
        wr(ADDR_CTRL_A, 16'h00c1);
        wr(ADDR_CTRL_A, 16'h00c9);
        settle();
        `CHK("pinOutA", 1'b0, pinOutA)
        rd_chk(ADDR_CTRL_A, 16'h00c1);
        rd_chk(ADDR_CTRL_B, 16'h0008);
        // Duty cycles in fast and phase correct modes
        pwm(16'h0009, 16'h0081, 16'h0080, 256, 129);
        pwm(16'h0009, 16'h00c1, 16'h0080, 256, 127);
        pwm(16'h0009, 16'h0081, 16'h00ff, 256, 256);
        pwm(16'h0001, 16'h0081, 16'h0040, 510, 128);
        pwm(16'h0001, 16'h00c1, 16'h0040, 510, 382);
        pwm(16'h0019, 16'h0053, 16'h0010, 34, 17);
        for (int v = 1; v >= 0; v--) begin
            ports(v[0]);
            `CHK("pinOutB", v[0], pinOutB)
        end
        wr(ADDR_CTRL_B, 16'h0009);
        wr(ADDR_CTRL_A, 16'h0041);
        for (int v = 1; v >= 0; v--) begin
            ports(v[0]);
            `CHK("pinOutA", v[0], pinOutA)
        end
        // Dual-slope toggle in mode 9, then compare at top holds high
        pwm(16'h0011, 16'h0041, 16'h0010, 64, 32);
        pwm(16'h0001, 16'h0081, 16'h00ff, 510, 510);
        // Overflow at the top of normal mode, then cleared
        wr(ADDR_CTRL_B, 16'h0000);
        wr(ADDR_CTRL_A, 16'h0000);
        wr(ADDR_COUNT, 16'hfff0);
        wr(ADDR_STATUS, 16'h0001);
        wr(ADDR_CTRL_B, 16'h0001);
        settle();
        `CHK("overflowFlag", 1'b0, overflowFlag)
        k = 0;
        while (overflowFlag !== 1'b1 && k < 40) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        `CHK("overflowFlag", 1'b1, overflowFlag)
        wr(ADDR_CTRL_B, 16'h0000);
        wr(ADDR_STATUS, 16'h0001);
        rd_chk(ADDR_STATUS, 16'h0000);
        finish_test();
    end
endmodule
`default_nettype wire
